// File: src/tchs_pkg.sv
// Purpose: Shared constants and types for the sensor configuration block
// Assumes: Temperatures in 1/16 degC two's complement, 13 bits used
// Notes:   Offsets, fields and the hysteresis and shutdown reset values live here only
package tchs_pkg;
  localparam logic [7:0]  CFG_ADDR       = 8'h01;
  localparam int          RSV_HI         = 15;
  localparam int          RSV_LO         = 11;
  localparam int          HYS_HI         = 10;
  localparam int          HYS_LO         = 9;
  localparam int          SHDN_BIT       = 8;
  localparam int          CTL_BIT        = 7;
  localparam int          AWL_BIT        = 6;
  localparam logic [1:0]  HYS_RESET      = 2'h0;
  localparam logic        SHDN_RESET     = 1'b0;
  localparam int          ABOVE_BIT      = 14;
  localparam int          BELOW_BIT      = 13;
  // Hysteresis in 1/16 degC steps: 1.5, 3 and 6 degC
  localparam logic [12:0] HYS_OFF_LSB    = 13'h0000;
  localparam logic [12:0] HYS_1P5_LSB    = 13'h0018;
  localparam logic [12:0] HYS_3_LSB      = 13'h0030;
  localparam logic [12:0] HYS_6_LSB      = 13'h0060;
  localparam int          TEMP_W         = 13;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [15:0] data;
  } tchs_wr_t;

  typedef struct packed {
    logic above;
    logic below;
    logic crit;
  } tchs_flags_t;
endpackage

// File: src/tchs_window.sv
// Purpose: Window comparator with hysteresis for one new temperature sample
// Assumes: Samples and limits are signed 1/16 degC values
// Notes:   Pure combinational; the caller registers the result
`timescale 1ns/100ps
`default_nettype none
module tchs_window #(
  parameter int W = 13
) (
  input  wire logic [W-1:0] temp_i,
  input  wire logic [W-1:0] upper_i,
  input  wire logic [W-1:0] lower_i,
  input  wire logic [W-1:0] crit_i,
  input  wire logic [W-1:0] hys_i,
  input  wire logic         above_i,
  input  wire logic         below_i,
  input  wire logic         crit_flag_i,
  output logic              above_o,
  output logic              below_o,
  output logic              crit_o
);
  logic signed [W:0] t;
  logic signed [W:0] up_rel;
  logic signed [W:0] lo_set;
  logic signed [W:0] cr_rel;
  logic signed [W:0] up_x;
  logic signed [W:0] lo_x;
  logic signed [W:0] cr_x;
  always_comb begin
    // Signed copies: a bare concatenation would make the compare unsigned
    t      = {temp_i[W-1], temp_i};
    up_x   = {upper_i[W-1], upper_i};
    lo_x   = {lower_i[W-1], lower_i};
    cr_x   = {crit_i[W-1], crit_i};
    up_rel = up_x - $signed({1'b0, hys_i});
    lo_set = lo_x - $signed({1'b0, hys_i});
    cr_rel = cr_x - $signed({1'b0, hys_i});
    // Set above the boundary, release at boundary minus hysteresis
    if (t > up_x) begin
      above_o = 1'b1; // [RULE_03]
    end else if (t <= up_rel) begin
      above_o = 1'b0; // [RULE_04]
    end else begin
      above_o = above_i;
    end
    if (t >= lo_x) begin
      below_o = 1'b0; // [RULE_05]
    end else if (t <= lo_set) begin
      below_o = 1'b1; // [RULE_06]
    end else begin
      below_o = below_i;
    end
    if (t >= cr_x) begin
      crit_o = 1'b1;
    end else if (t < cr_rel) begin
      crit_o = 1'b0;
    end else begin
      crit_o = crit_flag_i;
    end
  end
endmodule
`default_nettype wire

// File: src/tchs_config.sv
// Purpose: Config bits 15:6: hysteresis select, shutdown, lock gating
// Assumes: Host writes and reads arrive from the serial-bus front end
// Notes:   Sample strobe comes from the conversion timer outside
`timescale 1ns/100ps
`default_nettype none
// Operation
// [RULE_01] Host writes zero to configuration bits 15:11; they read zero.
// [RULE_02] Bits 10:9 select hysteresis off, 1.5, 3 or 6 degC.
// [RULE_03] Above flag sets when temperature exceeds upper boundary.
// [RULE_04] Above flag holds until temperature reaches upper minus hysteresis.
// [RULE_05] Below flag clears when temperature reaches lower boundary.
// [RULE_06] Below flag sets at or below lower minus hysteresis.
// [RULE_07] Alert pin thresholds use the same hysteresis.
// [RULE_08] Either lock set blocks changes to hysteresis select.
// [RULE_09] Bit 8 is shutdown; zero enables sensing, reset zero.
// [RULE_10] Shutdown stops diode, converter, conversions and events.
// [RULE_11] Shutdown cannot be set while locked; clearing always allowed.
// [RULE_12] Bus time-out detection stops while shut down.
// [RULE_13] Non-volatile reads are served regardless of shutdown.
// [RULE_14] Non-volatile writes are refused while shut down.
// [RULE_15] Temperature sensing is unavailable during shutdown.
// [RULE_16] Bit 7 critical lock sticks at one until power-on reset.
// [RULE_17] Bit 6 window lock sticks at one until power-on reset.
// [RULE_18] Clearing shutdown resumes conversions and events unaided.
module tchs_config #(
  parameter int W = tchs_pkg::TEMP_W
) (
  input  wire logic               core_clk_i,
  input  wire logic               nrst_i,
  input  wire tchs_pkg::tchs_wr_t host_wr_i,
  input  wire logic               sample_valid_i,
  input  wire logic [W-1:0]       sample_i,
  input  wire logic [W-1:0]       upper_i,
  input  wire logic [W-1:0]       lower_i,
  input  wire logic [W-1:0]       crit_i,
  input  wire logic               nv_wr_req_i,
  output logic [15:0]             cfg_rd_o,
  output tchs_pkg::tchs_flags_t   flags_o,
  output logic                    alert_o,
  output logic                    osc_en_o,
  output logic                    adc_en_o,
  output logic                    tout_en_o,
  output logic                    nv_rd_en_o,
  output logic                    nv_wr_go_o,
  output logic                    crit_wr_en_o,
  output logic                    win_wr_en_o
);
  // -------------------------------------------------------------
  // Configuration state
  // -------------------------------------------------------------
  logic [1:0] hys_sel;
  logic       shdn;
  logic       ctl_lock;
  logic       awl_lock;
  logic [1:0] next_hys_sel;
  logic       next_shdn;
  logic       next_ctl_lock;
  logic       next_awl_lock;
  logic       cfg_wr;
  logic       locked;
  logic [1:0] wr_hys;
  logic       wr_shdn;
  logic       wr_ctl;
  logic       wr_awl;

  function automatic logic [W-1:0] hys_amount(input logic [1:0] sel);
    unique case (sel)
      2'h0: hys_amount = W'(tchs_pkg::HYS_OFF_LSB);
      2'h1: hys_amount = W'(tchs_pkg::HYS_1P5_LSB);
      2'h2: hys_amount = W'(tchs_pkg::HYS_3_LSB);
      2'h3: hys_amount = W'(tchs_pkg::HYS_6_LSB);
    endcase
  endfunction

  always_comb begin
    cfg_wr        = host_wr_i.wr && (host_wr_i.addr == tchs_pkg::CFG_ADDR);
    locked        = ctl_lock | awl_lock;
    wr_hys        = host_wr_i.data[tchs_pkg::HYS_HI:tchs_pkg::HYS_LO];
    wr_shdn       = host_wr_i.data[tchs_pkg::SHDN_BIT];
    wr_ctl        = host_wr_i.data[tchs_pkg::CTL_BIT];
    wr_awl        = host_wr_i.data[tchs_pkg::AWL_BIT];
    next_hys_sel  = hys_sel;
    next_shdn     = shdn;
    next_ctl_lock = ctl_lock;
    next_awl_lock = awl_lock;
    if (cfg_wr) begin
      // Locks are judged as they stood before this write
      if (!locked) begin
        next_hys_sel = wr_hys;
      end // [RULE_08]
      if (!wr_shdn) begin
        next_shdn = 1'b0; // [RULE_11] [RULE_18]
      end else if (!locked) begin
        next_shdn = 1'b1; // [RULE_09] [RULE_11]
      end
      // Locks only ever set; power-on reset is the sole clear
      next_ctl_lock = ctl_lock | wr_ctl; // [RULE_16]
      next_awl_lock = awl_lock | wr_awl; // [RULE_17]
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hys_sel  <= tchs_pkg::HYS_RESET;
      shdn     <= tchs_pkg::SHDN_RESET;
      ctl_lock <= 1'b0;
      awl_lock <= 1'b0;
    end else begin
      hys_sel  <= next_hys_sel;
      shdn     <= next_shdn;
      ctl_lock <= next_ctl_lock;
      awl_lock <= next_awl_lock;
    end
  end

  // -------------------------------------------------------------
  // Window evaluation
  // -------------------------------------------------------------
  tchs_pkg::tchs_flags_t flags;
  tchs_pkg::tchs_flags_t next_flags;
  tchs_pkg::tchs_flags_t cmp;
  logic                  alert;
  logic                  next_alert;
  logic [W-1:0]          hys_lsb;
  logic                  take_sample;

  // Decode kept apart so the comparator input has a single source
  always_comb begin
    hys_lsb = hys_amount(hys_sel); // [RULE_02]
  end

  tchs_window #(
    .W (W)
  ) u_window (
    .temp_i      (sample_i),
    .upper_i     (upper_i),
    .lower_i     (lower_i),
    .crit_i      (crit_i),
    .hys_i       (hys_lsb),
    .above_i     (flags.above),
    .below_i     (flags.below),
    .crit_flag_i (flags.crit),
    .above_o     (cmp.above),
    .below_o     (cmp.below),
    .crit_o      (cmp.crit)
  );

  always_comb begin
    next_flags = flags;
    next_alert = alert;
    take_sample = sample_valid_i && !shdn;
    // Samples during shutdown are dropped; state freezes meanwhile
    if (take_sample) begin
      next_flags = cmp; // [RULE_10] [RULE_15]
      next_alert = cmp.above | cmp.below | cmp.crit; // [RULE_07]
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flags <= '0;
      alert <= 1'b0;
    end else begin
      flags <= next_flags;
      alert <= next_alert;
    end
  end

  // -------------------------------------------------------------
  // Registered outputs
  // -------------------------------------------------------------
  logic [15:0] next_rd;
  logic        next_go;
  logic        next_osc_en;
  logic        next_adc_en;
  logic        next_tout_en;
  logic        next_nv_rd_en;
  logic        next_crit_wr_en;
  logic        next_win_wr_en;

  always_comb begin
    next_rd = '0; // [RULE_01]
    next_rd[tchs_pkg::HYS_HI:tchs_pkg::HYS_LO] = next_hys_sel;
    next_rd[tchs_pkg::SHDN_BIT] = next_shdn;
    next_rd[tchs_pkg::CTL_BIT]  = next_ctl_lock;
    next_rd[tchs_pkg::AWL_BIT]  = next_awl_lock;
    next_go = nv_wr_req_i & ~next_shdn; // [RULE_14]
    // Oscillator, converter and time-out all hang on the one shutdown bit
    next_osc_en     = ~next_shdn; // [RULE_10] [RULE_18]
    next_adc_en     = ~next_shdn; // [RULE_10] [RULE_15]
    next_tout_en    = ~next_shdn; // [RULE_12]
    // Reads need no oscillator, so this path is never gated
    next_nv_rd_en   = 1'b1; // [RULE_13]
    next_crit_wr_en = ~next_ctl_lock; // [RULE_16]
    next_win_wr_en  = ~next_awl_lock; // [RULE_17]
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_rd_o     <= '0;
      flags_o      <= '0;
      alert_o      <= 1'b0;
      osc_en_o     <= 1'b0;
      adc_en_o     <= 1'b0;
      tout_en_o    <= 1'b0;
      nv_rd_en_o   <= 1'b0;
      nv_wr_go_o   <= 1'b0;
      crit_wr_en_o <= 1'b0;
      win_wr_en_o  <= 1'b0;
    end else begin
      cfg_rd_o     <= next_rd;
      flags_o      <= next_flags;
      alert_o      <= next_alert;
      osc_en_o     <= next_osc_en;
      adc_en_o     <= next_adc_en;
      tout_en_o    <= next_tout_en;
      nv_rd_en_o   <= next_nv_rd_en;
      nv_wr_go_o   <= next_go;
      crit_wr_en_o <= next_crit_wr_en;
      win_wr_en_o  <= next_win_wr_en;
    end
  end
endmodule
`default_nettype wire

// File: verif/tchs_config_asserts.sv
// Purpose: Port checks for the config block
// Assumes: One clock, async active-low reset
// Notes:   Bound from the bench top
`timescale 1ns/100ps
`default_nettype none
module tchs_config_asserts #(
  parameter int W = 13
) (
  input wire logic                  core_clk_i,
  input wire logic                  nrst_i,
  input wire logic                  sample_valid_i,
  input wire logic [W-1:0]          sample_i,
  input wire logic [W-1:0]          upper_i,
  input wire logic                  nv_wr_req_i,
  input wire logic [15:0]           cfg_rd_o,
  input wire tchs_pkg::tchs_flags_t flags_o,
  input wire logic                  alert_o,
  input wire logic                  adc_en_o,
  input wire logic                  tout_en_o,
  input wire logic                  nv_rd_en_o,
  input wire logic                  nv_wr_go_o,
  input wire logic                  win_wr_en_o
);
  logic armed;

  // Enables sit at zero through reset; judge them from the second edge on
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      armed <= 1'b0;
    end else begin
      armed <= 1'b1;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  a_rsv_read_zero: assert property (cfg_rd_o[15:11] == 5'h00)
    else $error("reserved bits not zero");
  a_hys_lock_hold: assert property ((cfg_rd_o[7] || cfg_rd_o[6])
    |=> $stable(cfg_rd_o[10:9])) else $error("hysteresis changed locked");
  a_shdn_lock_set: assert property ((cfg_rd_o[7] || cfg_rd_o[6])
    && !cfg_rd_o[8] |=> !cfg_rd_o[8]) else $error("shutdown set locked");
  a_shdn_stops_all: assert property (cfg_rd_o[8] |->
    !adc_en_o && !tout_en_o) else $error("converter on in shutdown");
  a_flags_frozen: assert property (cfg_rd_o[8] |=>
    $stable(flags_o)) else $error("flags moved in shutdown");
  a_nv_read_on: assert property (armed |-> nv_rd_en_o)
    else $error("nv read disabled");
  a_nv_write_gate: assert property (nv_wr_go_o |->
    $past(nv_wr_req_i) && !cfg_rd_o[8]) else $error("nv write bad");
  a_crit_lock_stick: assert property ($past(cfg_rd_o[7]) |->
    cfg_rd_o[7]) else $error("critical lock cleared");
  a_win_lock_gate: assert property (armed |->
    win_wr_en_o == !cfg_rd_o[6]) else $error("window write enable wrong");
  a_above_sets: assert property (sample_valid_i && !cfg_rd_o[8] &&
    ($signed(sample_i) > $signed(upper_i)) |=> flags_o.above)
    else $error("above flag not set");
  a_alert_follows: assert property (alert_o == (|flags_o))
    else $error("alert does not follow flags");
endmodule
`default_nettype wire

// File: verif/tchs_host.sv
// Purpose: Host model issuing configuration writes
// Assumes: One write pulse per go cycle
// Notes:   Reserved data bits always sent as zero
`timescale 1ns/100ps
`default_nettype none
module tchs_host (
  input  wire logic          clk_i,
  input  wire logic          go_i,
  input  wire logic [7:0]    addr_i,
  input  wire logic [15:0]   data_i,
  output tchs_pkg::tchs_wr_t host_wr_o
);
  // Idle address inverted so a stale match cannot hide
  always_ff @(posedge clk_i) begin
    host_wr_o.wr   <= go_i;
    host_wr_o.addr <= go_i ? addr_i : ~addr_i;
    host_wr_o.data <= data_i & 16'h07FF;
  end
endmodule
`default_nettype wire

// File: verif/thermal_config_hysteresis_shutdown_tb_top.sv
// Purpose: Directed bench for the config block
// Assumes: Crit limit kept out of reach
// Notes:   Lock test last; locks only clear at reset
`timescale 1ns/100ps
`default_nettype none
module thermal_config_hysteresis_shutdown_tb_top;
  localparam logic [12:0] UP = 13'h0500;
  localparam logic [12:0] LO = 13'h0100;
  logic clk = 1'b0, nrst = 1'b0, go = 1'b0, sv = 1'b0, nvq = 1'b0;
  logic [7:0] ad = 8'h00;
  logic [15:0] dat = 16'h0000, cfg;
  logic [12:0] t = 13'h0000;
  logic alert, osc, adc, tout, nvrd, nvgo, cwe, wwe;
  tchs_pkg::tchs_wr_t hw;
  tchs_pkg::tchs_flags_t fl;
  int bad_count = 0, samples_checked = 0;
  always #12.5 clk = ~clk;
  tchs_host host_u (.clk_i(clk), .go_i(go), .addr_i(ad), .data_i(dat),
    .host_wr_o(hw));
  tchs_config dut_u (.core_clk_i(clk), .nrst_i(nrst), .host_wr_i(hw),
    .sample_valid_i(sv), .sample_i(t), .upper_i(UP), .lower_i(LO),
    .crit_i(13'h0FFF), .nv_wr_req_i(nvq), .cfg_rd_o(cfg), .flags_o(fl),
    .alert_o(alert), .osc_en_o(osc), .adc_en_o(adc), .tout_en_o(tout),
    .nv_rd_en_o(nvrd), .nv_wr_go_o(nvgo), .crit_wr_en_o(cwe),
    .win_wr_en_o(wwe));
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk); go <= 1'b1; ad <= a; dat <= d;
    @(posedge clk); go <= 1'b0;
    @(posedge clk); #1;
  endtask
  task smp(input logic [12:0] v);
    @(posedge clk); sv <= 1'b1; t <= v;
    @(posedge clk); sv <= 1'b0; #1;
  endtask
  task nvw();
    @(posedge clk); nvq <= 1'b1;
    @(posedge clk); nvq <= 1'b0; #1;
  endtask
  task t_hys();
    logic [12:0] h;
    for (int i = 0; i < 4; i++) begin
      h = (i == 0) ? 13'h0000 : 13'h0018 << (i - 1);
      wr(8'h01, 16'(i) << 9);
      chk("cfg", cfg, 16'(i) << 9);
      smp(UP + 13'h0001);
      chk("above", fl.above, 16'h0001);
      smp(UP - h + 13'h0001);
      chk("alert", {fl.above, alert}, 16'h0003);
      smp(UP - h);
      chk("above", fl.above, 16'h0000);
      smp(LO - h - ((i == 0) ? 13'h0001 : 13'h0000));
      chk("below", fl.below, 16'h0001);
      smp(LO - 13'h0001);
      chk("below", fl.below, 16'h0001);
      smp(LO);
      chk("alert", {fl.below, alert}, 16'h0000);
    end
  endtask
  task t_shdn();
    wr(8'h01, 16'h0100);
    chk("cfg", cfg, 16'h0100);
    chk("en", {osc, adc, tout, nvrd}, 16'h0001);
    nvw();
    chk("nvgo", nvgo, 16'h0000);
    smp(UP + 13'h0001);
    chk("above", fl.above, 16'h0000);
    wr(8'h01, 16'h0000);
    chk("en", {osc, adc, tout, nvrd}, 16'h000F);
    nvw();
    chk("nvgo", nvgo, 16'h0001);
    smp(UP + 13'h0001);
    chk("above", fl.above, 16'h0001);
  endtask
  task t_lock();
    wr(8'h02, 16'h0600);
    chk("cfg", cfg, 16'h0000);
    wr(8'h01, 16'h01C0);
    chk("cfg", cfg, 16'h01C0);
    chk("wen", {cwe, wwe}, 16'h0000);
    wr(8'h01, 16'h0000);
    chk("cfg", cfg, 16'h00C0);
    wr(8'h01, 16'h0700);
    chk("cfg", cfg, 16'h00C0);
    // Only a reset may clear the locks
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    chk("cfg", cfg, 16'h0000);
    chk("wen", {cwe, wwe}, 16'h0003);
  endtask
  task report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk); #1;
    chk("cfg", cfg, 16'h0000);
    chk("en", {osc, adc, tout, nvrd, cwe, wwe}, 16'h003F);
    t_hys();
    t_shdn();
    t_lock();
    report_and_stop();
  end
endmodule
bind tchs_config tchs_config_asserts #(.W(W)) chk_u (.core_clk_i, .nrst_i,
  .sample_valid_i, .sample_i, .upper_i, .nv_wr_req_i, .cfg_rd_o, .flags_o,
  .alert_o, .adc_en_o, .tout_en_o, .nv_rd_en_o, .nv_wr_go_o, .win_wr_en_o);
`default_nettype wire
